// [stdw_desc_mem.sv]
`default_nettype none

// ****************************************************************
// Shared constants and types
// ****************************************************************
package stdw_pkg;
    localparam int           STDW_HDR_WORDS   = 4;
    localparam int           STDW_TILE_WORDS  = 6;
    localparam int           STDW_MAX_TILES   = 16;
    localparam int           STDW_DESC_WORDS  = STDW_HDR_WORDS + STDW_MAX_TILES * STDW_TILE_WORDS;
    localparam int           STDW_AW          = 22;
    // Register byte offsets
    localparam logic [7:0]   STDW_OFS_CTRL    = 8'h00;
    localparam logic [7:0]   STDW_OFS_DAP     = 8'h04;
    localparam logic [7:0]   STDW_OFS_BGCOL   = 8'h08;
    localparam logic [7:0]   STDW_OFS_LINES   = 8'h0c;
    localparam logic [7:0]   STDW_OFS_STATUS  = 8'h10;
    // Control fields
    localparam int           STDW_CTRL_EN     = 0;
    localparam int           STDW_CTRL_ILACE  = 1;
    // Reset values
    localparam logic [21:0]  STDW_DAP_RST     = 22'h000000;
    localparam logic [7:0]   STDW_BGCOL_RST   = 8'h00;
    localparam logic [11:0]  STDW_LINES_RST   = 12'h1e0;
    // Header word indices
    localparam logic [6:0]   STDW_H_LINES     = 7'h00;
    localparam logic [6:0]   STDW_H_LINK_LO   = 7'h01;
    localparam logic [6:0]   STDW_H_LINK_HI   = 7'h02;
    localparam logic [6:0]   STDW_H_NTILES    = 7'h03;
    // Tile word indices
    localparam logic [2:0]   STDW_T_STRIDE    = 3'h0;
    localparam logic [2:0]   STDW_T_ADDR_LO   = 3'h1;
    localparam logic [2:0]   STDW_T_ADDR_HI   = 3'h2;
    localparam logic [2:0]   STDW_T_DEPTH     = 3'h3;
    localparam logic [2:0]   STDW_T_FETCH     = 3'h4;
    localparam logic [2:0]   STDW_T_FLAGS     = 3'h5;
    localparam int           STDW_CFLAG_BIT   = 15;
    localparam int           STDW_FIELD_BIT   = 0;

    typedef enum logic [2:0] {
        STDW_IDLE  = 3'b000,
        STDW_FETCH = 3'b001,
        STDW_LWAIT = 3'b011,
        STDW_TLOAD = 3'b010,
        STDW_TOUT  = 3'b110,
        STDW_LEND  = 3'b111,
        STDW_FILL  = 3'b101,
        STDW_DONE  = 3'b100
    } stdw_state_t;

    typedef struct packed {
        logic [21:0] line_addr;
        logic [11:0] fetch_count;
        logic [3:0]  bpp;
        logic [3:0]  first_pixel_bit_pos;
        logic [3:0]  last_pixel_bit_pos;
        logic        bg_run;
        logic [11:0] bg_count;
    } stdw_tile_t;

    typedef struct packed {
        logic [7:0]  paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } stdw_apb_req_t;
endpackage

// ****************************************************************
// Descriptor storage, registered read
// ****************************************************************
module stdw_desc_mem
    import stdw_pkg::*;
#(
    parameter int DEPTH = STDW_DESC_WORDS,
    parameter int WIDTH = 16
) (
    input  wire logic             ref_clk,
    input  wire logic             clk_en,
    input  wire logic             we,
    input  wire logic [6:0]       waddr,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic [6:0]       raddr,
    output logic      [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge ref_clk) begin
        if (clk_en) begin
            if (we) begin
                mem[waddr] <= wdata;
            end
            rdata <= mem[raddr];
        end
    end
endmodule

`default_nettype wire

// [stdw_walker.sv]
// The register offsets and the APB slave port were chosen for this implementation.
`default_nettype none

module stdw_walker
    import stdw_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        vertical_blank_interval,
    input  wire logic        horizontal_blank_interval,
    input  wire logic        line_start,
    output logic             mem_req,
    output logic      [21:0] mem_addr,
    input  wire logic        mem_ack,
    input  wire logic [15:0] mem_rdata,
    output logic             tile_valid,
    output stdw_tile_t       tile,
    input  wire logic        tile_ready,
    output logic             bg_fill,
    output logic      [7:0]  background_field_colour,
    output logic             pixel_stall
);
    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        stdw_state_t st;
        logic        en;
        logic        ilace;
        logic [21:0] dap;
        logic [7:0]  bgcol;
        logic [11:0] act_lines;
        logic [31:0] prdata;
        logic        vb_q;
        logic [21:0] strip_addr;
        logic [6:0]  widx;
        logic [6:0]  wlast;
        logic [4:0]  ft;
        logic [2:0]  fw;
        logic [15:0] hdr_lines;
        logic [21:0] link;
        logic        cflag;
        logic [4:0]  ntiles;
        logic [4:0]  ti;
        logic [2:0]  tw;
        logic [15:0] line_in_strip;
        logic [11:0] scr_line;
        logic [15:0] b_stride;
        logic [15:0] b_depth;
        logic [15:0] b_fetch;
        logic [15:0] b_flags;
        logic [STDW_MAX_TILES-1:0][21:0] cur_addr;
    } stdw_regs_t;

    stdw_regs_t r_r;
    stdw_regs_t r_nxt;

    logic        apb_wr;
    logic        apb_rd;
    logic        addr_ok;
    logic        mem_we;
    logic [6:0]  mem_raddr;
    logic [15:0] mem_q;
    logic [21:0] step;
    logic [14:0] cnt_field;

    // ****************************************************************
    // Descriptor storage
    // ****************************************************************
    // full-size storage
    stdw_desc_mem #(
        .DEPTH (STDW_DESC_WORDS),
        .WIDTH (16)
    ) u_mem (
        .ref_clk (ref_clk),
        .clk_en  (clk_en),
        .we      (mem_we),
        .waddr   (r_r.widx),
        .wdata   (mem_rdata),
        .raddr   (mem_raddr),
        .rdata   (mem_q)
    );

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign addr_ok   = paddr == STDW_OFS_CTRL || paddr == STDW_OFS_DAP || paddr == STDW_OFS_BGCOL
                       || paddr == STDW_OFS_LINES || paddr == STDW_OFS_STATUS;
    assign apb_wr    = psel && penable && pwrite && addr_ok;
    assign apb_rd    = psel && !penable && !pwrite;
    assign pready    = 1'b1;
    assign pslverr   = psel && penable && !addr_ok;
    assign prdata    = r_r.prdata;
    assign mem_req   = r_r.st == STDW_FETCH;
    assign mem_addr  = 22'(r_r.strip_addr + {14'h0, r_r.widx, 1'b0});
    assign mem_we    = mem_req && mem_ack;
    assign mem_raddr = 7'(STDW_HDR_WORDS + r_r.ti * STDW_TILE_WORDS + r_r.tw);
    assign background_field_colour = r_r.bgcol;
    assign bg_fill   = r_r.st == STDW_FILL;
    // pixels wait on the block read
    assign pixel_stall = r_r.st == STDW_FETCH && !vertical_blank_interval;
    assign tile_valid  = r_r.st == STDW_TOUT && !horizontal_blank_interval;
    assign step      = r_r.ilace ? {5'h0, r_r.b_stride, 1'b0} : {6'h0, r_r.b_stride};
    assign cnt_field = mem_rdata[14:0];

    always_comb begin
        // first line starts at tile address
        tile.line_addr           = r_r.cur_addr[r_r.ti[3:0]];
        tile.fetch_count         = r_r.b_fetch[11:0];
        tile.bpp                 = r_r.b_depth[11:8];
        tile.first_pixel_bit_pos = r_r.b_depth[7:4];
        tile.last_pixel_bit_pos  = r_r.b_depth[3:0];
        // run length is the depth word's low twelve bits, unchanged
        tile.bg_run              = r_r.b_flags[STDW_FIELD_BIT];
        tile.bg_count            = r_r.b_depth[11:0];
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        r_nxt      = r_r;
        r_nxt.vb_q = vertical_blank_interval;

        if (apb_rd) begin
            case (paddr)
                STDW_OFS_CTRL:   r_nxt.prdata = {30'h0, r_r.ilace, r_r.en};
                STDW_OFS_DAP:    r_nxt.prdata = {10'h0, r_r.dap};
                STDW_OFS_BGCOL:  r_nxt.prdata = {24'h0, r_r.bgcol};
                STDW_OFS_LINES:  r_nxt.prdata = {20'h0, r_r.act_lines};
                STDW_OFS_STATUS: r_nxt.prdata = {r_r.line_in_strip, 1'b0, r_r.scr_line, r_r.st};
                default:         r_nxt.prdata = 32'h0;
            endcase
        end
        if (apb_wr) begin
            case (paddr)
                STDW_OFS_CTRL: begin
                    r_nxt.en    = pwdata[STDW_CTRL_EN];
                    r_nxt.ilace = pwdata[STDW_CTRL_ILACE];
                end
                STDW_OFS_DAP:   r_nxt.dap       = pwdata[21:0];
                STDW_OFS_BGCOL: r_nxt.bgcol     = pwdata[7:0];
                STDW_OFS_LINES: r_nxt.act_lines = pwdata[11:0];
                default: begin
                end
            endcase
        end

        case (r_r.st)
            STDW_FETCH: begin
                if (mem_ack) begin
                    if (r_r.widx == STDW_H_LINES) begin
                        r_nxt.hdr_lines = mem_rdata;
                    end
                    if (r_r.widx == STDW_H_LINK_LO) begin
                        r_nxt.link[15:0] = mem_rdata;
                    end
                    if (r_r.widx == STDW_H_LINK_HI) begin
                        r_nxt.link[21:16] = mem_rdata[5:0];
                    end
                    if (r_r.widx == STDW_H_NTILES) begin
                        r_nxt.cflag = mem_rdata[STDW_CFLAG_BIT];
                        r_nxt.ntiles = (cnt_field > 15'(STDW_MAX_TILES)) ? 5'(STDW_MAX_TILES) : cnt_field[4:0];
                        r_nxt.wlast  = 7'(STDW_HDR_WORDS - 1)
                                       + 7'(r_nxt.ntiles) * 7'(STDW_TILE_WORDS);
                    end
                    if (r_r.widx >= 7'(STDW_HDR_WORDS)) begin
                        if (r_r.fw == STDW_T_ADDR_LO) begin
                            r_nxt.cur_addr[r_r.ft[3:0]][15:0] = mem_rdata;
                        end
                        if (r_r.fw == STDW_T_ADDR_HI) begin
                            r_nxt.cur_addr[r_r.ft[3:0]][21:16] = mem_rdata[5:0];
                        end
                        if (r_r.fw == STDW_T_FLAGS) begin
                            r_nxt.fw = 3'h0;
                            r_nxt.ft = r_r.ft + 5'h1;
                        end else begin
                            r_nxt.fw = r_r.fw + 3'h1;
                        end
                    end
                    r_nxt.widx = r_r.widx + 7'h1;
                    if (r_r.widx >= STDW_H_NTILES && r_r.widx >= r_nxt.wlast) begin
                        r_nxt.line_in_strip = 16'h0;
                        r_nxt.st            = STDW_LWAIT;
                    end
                end
            end
            STDW_LWAIT: begin
                if (line_start) begin
                    r_nxt.ti = 5'h0;
                    r_nxt.tw = 3'h0;
                    r_nxt.st = (r_r.ntiles == 5'h0) ? STDW_LEND : STDW_TLOAD;
                end
            end
            STDW_TLOAD: begin
                r_nxt.tw = r_r.tw + 3'h1;
                case (r_r.tw - 3'h1)
                    STDW_T_STRIDE: r_nxt.b_stride = mem_q;
                    STDW_T_DEPTH:  r_nxt.b_depth  = mem_q;
                    STDW_T_FETCH:  r_nxt.b_fetch  = mem_q;
                    STDW_T_FLAGS:  r_nxt.b_flags  = mem_q;
                    default: begin
                    end
                endcase
                if (r_r.tw == 3'(STDW_TILE_WORDS)) begin
                    r_nxt.st = STDW_TOUT;
                end
            end
            STDW_TOUT: begin
                // tiles past the line end are dropped
                if (tile_ready || horizontal_blank_interval) begin
                    r_nxt.cur_addr[r_r.ti[3:0]] = 22'(r_r.cur_addr[r_r.ti[3:0]] + step);
                    r_nxt.ti = r_r.ti + 5'h1;
                    r_nxt.tw = 3'h0;
                    r_nxt.st = (r_r.ti + 5'h1 == r_r.ntiles) ? STDW_LEND : STDW_TLOAD;
                end
            end
            STDW_LEND: begin
                r_nxt.scr_line      = r_r.scr_line + 12'h1;
                r_nxt.line_in_strip = r_r.line_in_strip + 16'h1;
                if (r_r.scr_line + 12'h1 >= r_r.act_lines) begin
                    // lower part beyond active area discarded
                    r_nxt.st = STDW_DONE;
                end else if (r_r.line_in_strip == r_r.hdr_lines) begin
                    if (r_r.cflag) begin
                        r_nxt.st = STDW_FILL;
                    end else begin
                        r_nxt.strip_addr = r_r.link;
                        r_nxt.widx       = 7'h0;
                        r_nxt.wlast      = STDW_H_NTILES;
                        r_nxt.ft         = 5'h0;
                        r_nxt.fw         = 3'h0;
                        r_nxt.st         = STDW_FETCH;
                    end
                end else begin
                    r_nxt.st = STDW_LWAIT;
                end
            end
            STDW_IDLE, STDW_FILL, STDW_DONE: begin
            end
            default: r_nxt.st = STDW_IDLE;
        endcase

        // frame restarts from the pointer at vertical blank
        if (vertical_blank_interval && !r_r.vb_q) begin
            r_nxt.st         = r_r.en ? STDW_FETCH : STDW_IDLE;
            r_nxt.strip_addr = r_r.dap;
            r_nxt.widx       = 7'h0;
            r_nxt.wlast      = STDW_H_NTILES;
            r_nxt.ft         = 5'h0;
            r_nxt.fw         = 3'h0;
            r_nxt.scr_line   = 12'h0;
        end
        if (!r_r.en) begin
            r_nxt.st = STDW_IDLE;
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            r_r           <= '0;
            r_r.st        <= STDW_IDLE;
            r_r.dap       <= STDW_DAP_RST;
            r_r.bgcol     <= STDW_BGCOL_RST;
            r_r.act_lines <= STDW_LINES_RST;
            r_r.wlast     <= STDW_H_NTILES;
        end else if (clk_en) begin
            r_r <= r_nxt;
        end
    end
endmodule

`default_nettype wire

// [stdw_mem_model.sv]
`default_nettype none

module stdw_mem_model (
    input  wire logic        ref_clk,
    input  wire logic [3:0]  lat,
    input  wire logic        mem_req,
    input  wire logic [21:0] mem_addr,
    output logic             mem_ack,
    output logic      [15:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Word store answering after lat idle cycles
    // ****************************************
    // store acts as DRAM, first tile depth free
    logic [15:0] mem    [0:4095];
    logic [3:0]  wait_r = 4'h0;

    initial begin
        mem_ack   = 1'b0;
        mem_rdata = 16'h0000;
    end

    always @(posedge ref_clk) begin
        if (mem_req && !mem_ack && wait_r >= lat) begin
            mem_ack   <= 1'b1;
            mem_rdata <= mem[mem_addr[12:1]];
            wait_r    <= 4'h0;
        end else begin
            // Data lines do not hold a value outside an answer
            mem_ack   <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_req && !mem_ack) begin
                wait_r <= wait_r + 4'h1;
            end
        end
    end
endmodule

`default_nettype wire

// [stdw_walker_sva.sv]
`default_nettype none

module stdw_walker_sva
    import stdw_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        clk_en,
    input wire logic        vertical_blank_interval,
    input wire logic        horizontal_blank_interval,
    input wire logic        mem_req,
    input wire logic [21:0] mem_addr,
    input wire logic        mem_ack,
    input wire logic        tile_valid,
    input wire stdw_tile_t  tile,
    input wire logic        tile_ready,
    input wire logic        bg_fill,
    input wire logic        pixel_stall
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Strip read and tile stream checks
    // ****************************************
    logic [7:0] cnt_r;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 8'h00;
        end else if (!mem_req) begin
            cnt_r <= 8'h00;
        end else if (mem_ack && clk_en) begin
            cnt_r <= cnt_r + 8'h01;
        end
    end

    AST_FRAME_FETCH: assert property ($rose(vertical_blank_interval) && clk_en |=> mem_req)
        else $error("no descriptor read after vertical blank start");
    AST_ADDR_STEP: assert property ((mem_req && mem_ack && clk_en) ##1 mem_req |->
        mem_addr == $past(mem_addr) + 22'h2)
        else $error("descriptor word address not sequential");
    AST_ADDR_HOLD: assert property (mem_req && !mem_ack |=> mem_req && mem_addr == $past(mem_addr))
        else $error("descriptor request dropped or moved without answer");
    AST_STALL: assert property (pixel_stall == (mem_req && !vertical_blank_interval))
        else $error("pixel stall does not match strip read");
    AST_TILE_HOLD: assert property (tile_valid && !tile_ready && clk_en ##1 !horizontal_blank_interval |->
        tile_valid && $stable(tile))
        else $error("tile changed before it was taken");
    AST_FILL_QUIET: assert property (bg_fill |-> !tile_valid && !mem_req)
        else $error("tile or read active during background fill");
    AST_BG_COUNT: assert property (tile_valid && tile.bg_run |->
        tile.bg_count == {tile.bpp, tile.first_pixel_bit_pos, tile.last_pixel_bit_pos})
        else $error("background run count not built from the three fields");
    AST_BLOCK_LEN: assert property ($fell(mem_req) |-> cnt_r <= 8'h64 && cnt_r % 8'h06 == 8'h04)
        else $error("strip block read length not header plus whole tiles");

    cover property ($fell(mem_req));
    cover property (tile_valid && tile_ready);
    cover property ($rose(bg_fill));
endmodule

bind stdw_walker stdw_walker_sva i_stdw_walker_sva (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .vertical_blank_interval(vertical_blank_interval),
    .horizontal_blank_interval(horizontal_blank_interval), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .tile_valid(tile_valid),
    .tile(tile), .tile_ready(tile_ready), .bg_fill(bg_fill), .pixel_stall(pixel_stall));

`default_nettype wire

// [stdw_walker_tb.sv]
`default_nettype none

module stdw_walker_tb
    import stdw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Bench signals, strip images and tasks
    // ****************************************
    logic          ref_clk, rst_n, clk_en, vertical_blank_interval, horizontal_blank_interval, line_start, tile_ready, perr;
    logic          pready, pslverr, mem_req, mem_ack, tile_valid, bg_fill, pixel_stall;
    logic [31:0]   prdata, rd;
    logic [21:0]   mem_addr;
    logic [15:0]   mem_rdata;
    logic [7:0]    colour;
    logic [3:0]    lat;
    stdw_apb_req_t apb;
    stdw_tile_t    tile, t;
    logic [21:0]   adr_q[$];
    int            n_fail, n_checks;
    // two linked strips at 0x100 and 0x200, first two lines tall, wide first tile
    logic [15:0]   img [0:25] = '{16'h0001, 16'h0200, 16'h0000, 16'h0002,
        16'h0040, 16'h1000, 16'h0000, 16'h0812, 16'h004e, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0063, 16'h0000, 16'h0001,
        16'h0000, 16'h0000, 16'h0000, 16'h8001, 16'h0020, 16'h3000, 16'h0000, 16'h0812, 16'h0010, 16'h0000};

    stdw_walker i_stdw_walker (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .paddr(apb.paddr), .psel(apb.psel),
        .penable(apb.penable), .pwrite(apb.pwrite), .pwdata(apb.pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .vertical_blank_interval(vertical_blank_interval), .horizontal_blank_interval(horizontal_blank_interval), .line_start(line_start), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .tile_valid(tile_valid), .tile(tile),
        .tile_ready(tile_ready), .bg_fill(bg_fill), .background_field_colour(colour), .pixel_stall(pixel_stall));
    stdw_mem_model i_stdw_mem_model (.ref_clk(ref_clk), .lat(lat), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata));

    always #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (mem_req && mem_ack) adr_q.push_back(mem_addr);

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        if (n_fail == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic guard(input int k);
        if (k >= 1000) begin
            n_fail++;
            end_sim();
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge ref_clk);
        apb <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
        @(posedge ref_clk);
        apb.penable <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 1000);
        guard(k);
        rd = prdata;
        perr = pslverr;
        apb.psel <= 1'b0;
        apb.penable <= 1'b0;
    endtask

    task automatic wait_sig(input int s, input logic v);
        int k;
        k = 0;
        do begin
            @(negedge ref_clk);
            k++;
        end while ((s == 0 ? mem_req : s == 1 ? tile_valid : bg_fill) !== v && k < 1000);
        guard(k);
    endtask

    task automatic take_tile();
        wait_sig(1, 1'b1);
        t = tile;
        @(posedge ref_clk);
        tile_ready <= 1'b1;
        @(posedge ref_clk);
        tile_ready <= 1'b0;
    endtask

    task automatic new_line(input logic last);
        @(posedge ref_clk);
        horizontal_blank_interval <= 1'b1;
        if (last) wait_sig(0, 1'b0);
        @(posedge ref_clk);
        horizontal_blank_interval <= 1'b0;
        line_start <= 1'b1;
        @(posedge ref_clk);
        line_start <= 1'b0;
    endtask

    task automatic frame(input logic il, input logic [3:0] bpp);
        i_stdw_mem_model.mem[12'h087] = {4'h0, bpp, 8'h12};
        xfer(1'b1, STDW_OFS_CTRL, {30'h0, il, 1'b1});
        adr_q.delete();
        @(posedge ref_clk);
        vertical_blank_interval <= 1'b1;
        wait_sig(0, 1'b1);
        wait_sig(0, 1'b0);
        @(posedge ref_clk);
        vertical_blank_interval <= 1'b0;
        for (int ln = 0; ln < 2; ln++) begin
            new_line(1'b0);
            take_tile();
            chk(t.line_addr, 22'h1000 + (ln == 1 ? (il ? 22'h80 : 22'h40) : 22'h0));
            chk({t.bpp, t.first_pixel_bit_pos, t.last_pixel_bit_pos, t.bg_run}, {bpp, 8'h12, 1'b0});
            chk(t.fetch_count, 12'h04e);
            if (ln == 1 && il) begin
                wait_sig(1, 1'b1);
                @(posedge ref_clk);
                horizontal_blank_interval <= 1'b1;
                @(negedge ref_clk);
                chk(tile_valid, 1'b0);
                @(posedge ref_clk);
                horizontal_blank_interval <= 1'b0;
            end else begin
                take_tile();
                chk({t.bg_run, t.bg_count}, {1'b1, 12'h063});
            end
        end
        wait_sig(0, 1'b1);
        chk(pixel_stall, 1'b1);
        new_line(1'b1);
        take_tile();
        chk(t.line_addr, 22'h3000);
        new_line(1'b0);
        wait_sig(2, 1'b1);
        chk(colour, 8'h5a);
        chk(adr_q.size(), 26);
        chk(adr_q[0], 22'h100);
        chk(adr_q[16], 22'h200);
        chk(adr_q[25], 22'h212);
    endtask

    initial begin
        ref_clk = 1'b0;
        rst_n = 1'b0;
        clk_en = 1'b1;
        vertical_blank_interval = 1'b0;
        horizontal_blank_interval = 1'b1;
        line_start = 1'b0;
        tile_ready = 1'b0;
        lat = 4'h0;
        apb = '0;
        n_fail = 0;
        n_checks = 0;
        for (int i = 0; i < 26; i++) i_stdw_mem_model.mem[(i < 16 ? 12'h080 : 12'h0f0) + 12'(i)] = img[i];
        repeat (16) @(posedge ref_clk);
        chk({mem_req, tile_valid, bg_fill, pixel_stall, pready}, 5'h01);
        rst_n <= 1'b1;
        xfer(1'b0, STDW_OFS_DAP, 32'h0);
        chk(rd, {10'h000, STDW_DAP_RST});
        xfer(1'b0, STDW_OFS_LINES, 32'h0);
        chk(rd, {20'h00000, STDW_LINES_RST});
        xfer(1'b1, STDW_OFS_DAP, 32'h100);
        xfer(1'b1, STDW_OFS_BGCOL, 32'h5a);
        clk_en <= 1'b0;
        xfer(1'b1, STDW_OFS_BGCOL, 32'ha5);
        clk_en <= 1'b1;
        xfer(1'b0, STDW_OFS_BGCOL, 32'h0);
        chk(rd, 32'h5a);
        xfer(1'b1, STDW_OFS_LINES, 32'h010);
        xfer(1'b1, 8'h14, 32'hffff_ffff);
        chk(perr, 1'b1);
        xfer(1'b0, 8'h14, 32'h0);
        chk({perr, rd}, 33'h1_0000_0000);
        xfer(1'b0, STDW_OFS_DAP, 32'h0);
        chk(rd, 32'h100);
        frame(1'b0, 4'h8);
        lat <= 4'h3;
        frame(1'b1, 4'h4);
        xfer(1'b0, STDW_OFS_STATUS, 32'h0);
        chk(rd, {16'h0001, 1'b0, 12'h003, STDW_FILL});
        end_sim();
    end
endmodule

`default_nettype wire
